// file: hw/rsc_aux_div.sv
`timescale 1ns/10ps
`default_nettype none

// ****************
// Auxiliary clock divider
// ****************
module rsc_aux_div
	import rsc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_aux_clk_s,
	input wire rsc_pkg::rsc_div_sel_t i_sel,
	output logic o_div_clk
);
	logic aux_d_r;
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic out_nxt;
	wire aux_rise = i_aux_clk_s & ~aux_d_r;
	wire cnt_wrap = (cnt_r >= i_sel);
	wire [2:0] half = 3'((4'(i_sel) + 4'h1) >> 1);

	// Divide by sel+1, zero stops the divider
	assign cnt_nxt = cnt_wrap ? 3'h0 : cnt_r + 3'h1;
	assign out_nxt = (i_sel != 3'h0) && (cnt_nxt < half);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aux_d_r <= 1'b0;
			cnt_r <= 3'h0;
			o_div_clk <= 1'b0;
		end else begin
			aux_d_r <= i_aux_clk_s;
			if (i_sel == 3'h0) begin
				cnt_r <= 3'h0;
				o_div_clk <= 1'b0;
			end else if (aux_rise) begin
				cnt_r <= cnt_nxt;
				o_div_clk <= out_nxt;
			end
		end
	end
endmodule : rsc_aux_div

`default_nettype wire

// file: hw/rsc_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ****************
// Two-stage synchroniser
// ****************
module rsc_sync #(
	parameter int W = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_r;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule : rsc_sync

`default_nettype wire

// file: hw/rsc_top.sv
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`include "rsc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module rsc_top
	import rsc_pkg::*;
#(
	parameter int ME_CYC = `RSC_ME_CYC,
	parameter int PPS_CYC = `RSC_PPS_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_hw_rst_n,
	input wire logic i_test_mode,
	input wire logic i_aux_clock_in,
	input wire rsc_pkg::rsc_div_sel_t i_aux_clock_divide_select,
	input wire logic i_external_interrupt_in_a_n,
	input wire logic i_external_interrupt_in_b_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_host_bus_drive_en,
	output logic o_interrupt_request_out_n,
	output logic o_measurement_epoch_out,
	output logic o_pulse_per_second_out,
	output logic o_antenna_switch_epoch_out,
	output logic [3:0] o_antenna_select_out,
	output rsc_pkg::rsc_port_t o_general_output_port,
	output logic o_divided_aux_clock_out,
	output logic [11:0] o_channel_enable
);
	import rsc_pkg::*;

	// ****************
	// Reset generation
	// ****************
	logic rst_meta_r;
	logic rst_n_r;
	logic soft_rst_r;
	rsc_state_t state_r;
	logic [5:0] init_cnt_r;

	always_ff @(posedge i_ref_clk or negedge i_hw_rst_n) begin
		if (!i_hw_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	wire core_rst = i_sys_rst | soft_rst_r;
	wire init_busy = (state_r == RSC_INIT);

	// ****************
	// Input synchronisers
	// ****************
	logic [3:0] sync_s;
	wire test_s = sync_s[0];
	wire aux_s = sync_s[1];
	wire ext_a_s = sync_s[2];
	wire ext_b_s = sync_s[3];

	rsc_sync #(.W(4)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n_r),
		.i_async({~i_external_interrupt_in_b_n,
			~i_external_interrupt_in_a_n,
			i_aux_clock_in, i_test_mode}),
		.o_sync(sync_s)
	);

	rsc_div_sel_t div_sel_m_r;
	rsc_div_sel_t div_sel_r;

	// Two stages, the select pins are outside the core clock domain
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			div_sel_m_r <= 3'h0;
			div_sel_r <= 3'h0;
		end else begin
			div_sel_m_r <= i_aux_clock_divide_select;
			div_sel_r <= div_sel_m_r;
		end
	end

	// Divider is spared by soft reset
	rsc_aux_div u_div (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n_r),
		.i_aux_clk_s(aux_s),
		.i_sel(div_sel_r),
		.o_div_clk(o_divided_aux_clock_out)
	);

	// ****************
	// Register initialisation
	// ****************
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= RSC_INIT;
			init_cnt_r <= 6'h00;
		end else if (core_rst) begin
			state_r <= RSC_INIT;
			init_cnt_r <= 6'h00;
		end else begin
			case (state_r)
				RSC_INIT: begin
					init_cnt_r <= init_cnt_r + 6'h01;
					if (init_cnt_r == `RSC_INIT_CYCLES - 6'h01) begin
						state_r <= RSC_RUN;
					end
				end
				RSC_RUN: begin
					init_cnt_r <= init_cnt_r;
				end
				default: begin
					state_r <= RSC_INIT;
				end
			endcase
		end
	end

	// ****************
	// Bus decode
	// ****************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	logic ack_r;
	wire req = i_wb_cyc & i_wb_stb & ~ack_r & ~init_busy;
	wire wr = req & i_wb_we;
	wire wr_soft = wr & hit(i_wb_adr, `RSC_ADR_SOFT_RST);
	wire wr_port = wr & hit(i_wb_adr, `RSC_ADR_OUT_PORT);
	wire wr_ant = wr & i_wb_sel[0] & hit(i_wb_adr, `RSC_ADR_ANT_CTRL);
	wire wr_chan = wr & hit(i_wb_adr, `RSC_ADR_CHAN_MODE);
	wire wr_ic = wr & i_wb_sel[0] & hit(i_wb_adr, `RSC_ADR_INT_CTRL);
	wire wr_st = wr & i_wb_sel[0] & hit(i_wb_adr, `RSC_ADR_STATUS);

	// ****************
	// Registers
	// ****************
	rsc_port_t port_r;
	logic [11:0] chan_r;
	logic int_en_r;
	logic me_flag_r;
	logic [1:0] ant_idx_r;
	logic ant_valid_r;
	logic me_tick;
	logic [7:0] ase_cnt_r;
	logic [31:0] rd_nxt;
	logic [31:0] rd_r;

	function automatic logic [11:0] merge12(input logic [11:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge12 = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge12

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			port_r <= `RSC_RST_OUT_PORT;
			chan_r <= `RSC_RST_CHAN_MODE;
			int_en_r <= 1'b0;
			ant_idx_r <= 2'h0;
			ant_valid_r <= 1'b0;
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_soft;
			if (core_rst) begin
				port_r <= `RSC_RST_OUT_PORT;
				chan_r <= `RSC_RST_CHAN_MODE;
				int_en_r <= 1'b0;
				ant_idx_r <= 2'h0;
				ant_valid_r <= 1'b0;
			end else begin
				if (wr_port) begin
					port_r <= merge12(port_r, i_wb_dat, i_wb_sel);
				end
				if (wr_chan) begin
					chan_r <= merge12(chan_r, i_wb_dat, i_wb_sel);
				end
				if (wr_ic) begin
					int_en_r <= i_wb_dat[`RSC_IC_ME_EN];
				end
				if (wr_ant) begin
					ant_idx_r <= i_wb_dat[1:0];
					ant_valid_r <= 1'b1;
				end
			end
		end
	end

	// Epoch flag: a new epoch wins over a clear
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			me_flag_r <= 1'b0;
		end else if (me_tick) begin
			me_flag_r <= 1'b1;
		end else if (core_rst) begin
			me_flag_r <= 1'b0;
		end else if (wr_st && i_wb_dat[`RSC_ST_ME_FLAG]) begin
			me_flag_r <= 1'b0;
		end
	end

	// ****************
	// Read data and ack
	// ****************
	always_comb begin
		rd_nxt = 32'h00000000;
		case (i_wb_adr)
			`RSC_ADR_OUT_PORT: rd_nxt[11:0] = port_r;
			`RSC_ADR_ANT_CTRL: rd_nxt[1:0] = ant_idx_r;
			`RSC_ADR_CHAN_MODE: rd_nxt[11:0] = chan_r;
			`RSC_ADR_INT_CTRL: rd_nxt[`RSC_IC_ME_EN] = int_en_r;
			`RSC_ADR_STATUS: begin
				rd_nxt[`RSC_ST_BUSY] = init_busy;
				rd_nxt[`RSC_ST_TEST] = test_s;
				rd_nxt[`RSC_ST_ME_FLAG] = me_flag_r;
			end
			default: rd_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ack_r <= 1'b0;
			rd_r <= 32'h00000000;
		end else begin
			ack_r <= req;
			rd_r <= (req && !i_wb_we) ? rd_nxt : 32'h00000000;
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rd_r;
	// Bus released at once by the reset pin
	assign o_host_bus_drive_en = ack_r & ~i_wb_we & i_hw_rst_n;

	// ****************
	// Epoch and PULSE_PER_SECOND_OUT timing, spared by soft reset
	// ****************
	logic [31:0] me_cnt_r;
	logic [31:0] pps_cnt_r;
	logic [7:0] me_w_r;
	logic [7:0] pps_w_r;
	wire [31:0] me_top = test_s ? `RSC_TEST_CYC : 32'(ME_CYC);
	wire [31:0] pps_top = test_s ? `RSC_TEST_CYC : 32'(PPS_CYC);
	wire pps_tick = (pps_cnt_r >= pps_top - 32'h00000001);

	assign me_tick = (me_cnt_r >= me_top - 32'h00000001);

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			me_cnt_r <= 32'h00000000;
			pps_cnt_r <= 32'h00000000;
			me_w_r <= 8'h00;
			pps_w_r <= 8'h00;
		end else if (i_sys_rst) begin
			me_cnt_r <= 32'h00000000;
			pps_cnt_r <= 32'h00000000;
			me_w_r <= 8'h00;
			pps_w_r <= 8'h00;
		end else begin
			me_cnt_r <= me_tick ? 32'h00000000 : me_cnt_r + 32'h00000001;
			pps_cnt_r <= pps_tick ? 32'h00000000 : pps_cnt_r + 32'h00000001;
			me_w_r <= me_tick ? `RSC_EPOCH_PULSE :
				(me_w_r != 8'h00 ? me_w_r - 8'h01 : 8'h00);
			pps_w_r <= pps_tick ? `RSC_EPOCH_PULSE :
				(pps_w_r != 8'h00 ? pps_w_r - 8'h01 : 8'h00);
		end
	end

	assign o_measurement_epoch_out = (me_w_r != 8'h00);
	assign o_pulse_per_second_out = (pps_w_r != 8'h00);

	// ****************
	// Antenna switching
	// ****************
	logic [3:0] ant_r;

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ase_cnt_r <= 8'h00;
			ant_r <= `RSC_RST_ANT_SEL;
		end else if (core_rst) begin
			ase_cnt_r <= 8'h00;
			ant_r <= `RSC_RST_ANT_SEL;
		end else begin
			ase_cnt_r <= wr_ant ? `RSC_EPOCH_PULSE :
				(ase_cnt_r != 8'h00 ? ase_cnt_r - 8'h01 : 8'h00);
			ant_r <= ant_valid_r ? 4'(4'h1 << ant_idx_r) : 4'h0;
		end
	end

	assign o_antenna_switch_epoch_out = (ase_cnt_r != 8'h00);
	assign o_antenna_select_out = ant_r;
	assign o_general_output_port = port_r;
	assign o_channel_enable = chan_r;

	// ****************
	// Interrupt output
	// ****************
	logic int_n_r;
	wire int_any = ext_a_s | ext_b_s | (me_flag_r & int_en_r);

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			int_n_r <= 1'b1;
		end else begin
			int_n_r <= ~int_any;
		end
	end

	// Combinational path from the external inputs while reset is held
	assign o_interrupt_request_out_n = i_hw_rst_n ? int_n_r :
		(i_external_interrupt_in_a_n & i_external_interrupt_in_b_n);

	// ****************
	// Checks
	// ****************
	logic [6:0] since_rst_r;

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			since_rst_r <= 7'h00;
		end else if (core_rst) begin
			since_rst_r <= 7'h00;
		end else if (since_rst_r != 7'h7F) begin
			since_rst_r <= since_rst_r + 7'h01;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	sequence soft_wr_s;
		wr_soft ##1 soft_rst_r;
	endsequence

	chk_outputs_reset_low: assert property (
		!i_hw_rst_n |-> !o_measurement_epoch_out && !o_pulse_per_second_out
		&& !o_antenna_switch_epoch_out && o_antenna_select_out == 4'h0
		&& o_general_output_port == 12'h000 && !o_divided_aux_clock_out)
		else $error("output active during hardware reset");
	chk_bus_float_reset: assert property (
		!i_hw_rst_n |-> !o_host_bus_drive_en)
		else $error("data bus driven during reset");
	chk_int_comb_reset: assert property (
		!i_hw_rst_n |-> o_interrupt_request_out_n ==
		(i_external_interrupt_in_a_n & i_external_interrupt_in_b_n))
		else $error("interrupt not from external inputs in reset");
	chk_int_from_epoch: assert property (
		(rst_n_r && i_hw_rst_n && me_flag_r && int_en_r) ##1 i_hw_rst_n
		|-> !o_interrupt_request_out_n)
		else $error("epoch interrupt not raised next edge");
	chk_init_length: assert property (
		$rose(state_r == RSC_RUN) |-> since_rst_r == 7'h20)
		else $error("initialisation not 32 cycles");
	chk_no_ack_busy: assert property (
		rst_n_r && init_busy && !ack_r |=> !o_wb_ack)
		else $error("access answered during initialisation");
	chk_soft_pulse_one: assert property (
		rst_n_r && i_hw_rst_n && wr_soft |=> soft_rst_r ##1 !soft_rst_r)
		else $error("soft reset not a single pulse");
	chk_soft_chan_off: assert property (
		(rst_n_r && i_hw_rst_n) and soft_wr_s |=> chan_r == 12'h000
		&& init_busy)
		else $error("soft reset left channels on");
	chk_soft_spares_pps: assert property (
		rst_n_r && i_hw_rst_n && soft_rst_r && !pps_tick
		|=> pps_cnt_r == $past(pps_cnt_r) + 32'h00000001)
		else $error("soft reset disturbed pps timing");
	chk_div_stopped: assert property (
		rst_n_r && i_hw_rst_n && div_sel_r == 3'h0 ##1 div_sel_r == 3'h0
		|-> !o_divided_aux_clock_out)
		else $error("divider runs with select zero");
endmodule : rsc_top

`default_nettype wire

// file: inc/rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ****************
// Register offsets
// ****************
`define RSC_ADR_SOFT_RST 8'h00
`define RSC_ADR_OUT_PORT 8'h04
`define RSC_ADR_ANT_CTRL 8'h08
`define RSC_ADR_CHAN_MODE 8'h0C
`define RSC_ADR_INT_CTRL 8'h10
`define RSC_ADR_STATUS 8'h14

// ****************
// Field positions
// ****************
`define RSC_ST_BUSY 0
`define RSC_ST_TEST 1
`define RSC_ST_ME_FLAG 2
`define RSC_IC_ME_EN 0

// ****************
// Reset values
// ****************
`define RSC_RST_OUT_PORT 12'h000
`define RSC_RST_CHAN_MODE 12'h000
`define RSC_RST_ANT_SEL 4'h0

// ****************
// Timing
// ****************
`define RSC_INIT_CYCLES 6'h20
`define RSC_EPOCH_PULSE 8'h80
`define RSC_CORE_HZ 100000000
`define RSC_ME_PERIOD_US 1000
`define RSC_PPS_PERIOD_MS 1000
`define RSC_ME_CYC (`RSC_ME_PERIOD_US * (`RSC_CORE_HZ / 1000000))
`define RSC_PPS_CYC (`RSC_PPS_PERIOD_MS * (`RSC_CORE_HZ / 1000))
`define RSC_TEST_CYC 32'h00000100

`endif

// file: inc/rsc_pkg.sv
package rsc_pkg;
	typedef logic [2:0] rsc_div_sel_t;
	typedef logic [11:0] rsc_port_t;
	typedef enum logic [0:0] {
		RSC_INIT = 1'b0,
		RSC_RUN = 1'b1
	} rsc_state_t;
endpackage : rsc_pkg

// file: testbench/rsc_host_bfm.sv
`timescale 1ns/10ps
`default_nettype none

// ****************
// Host model: classic Wishbone master
// ****************
module rsc_host_bfm (
	input wire logic i_ref_clk,
	input wire logic i_ack,
	input wire logic [31:0] i_dat,
	output logic o_cyc,
	output logic o_stb,
	output logic o_we,
	output logic [7:0] o_adr,
	output logic [31:0] o_dat,
	output logic [3:0] o_sel
);
	initial begin
		o_cyc = 1'h0;
		o_stb = 1'h0;
		o_we = 1'h0;
		o_adr = 8'h00;
		o_dat = 32'h0;
		o_sel = 4'h0;
	end

	// Holds the request until ack is sampled; init stalls are waited out
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output int n);
		n = 0;
		@(posedge i_ref_clk);
		o_cyc <= 1'h1;
		o_stb <= 1'h1;
		o_we <= w;
		o_adr <= a;
		o_dat <= d;
		o_sel <= 4'hF;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (i_ack !== 1'h1);
		rd = i_dat;
		o_cyc <= 1'h0;
		o_stb <= 1'h0;
		o_we <= 1'h0;
		o_dat <= ~d;
	endtask : xfer
endmodule : rsc_host_bfm

`default_nettype wire

// file: testbench/tb_reset_state_control.sv
`include "rsc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

// ****************
// Reset state control bench
// ****************
module tb_reset_state_control;
	import rsc_pkg::*;
	localparam int ME = 300;
	localparam int PULSE_PER_SECOND_OUT = 1000;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic hw_n = 1'h0;
	logic aux = 1'h0;
	rsc_div_sel_t dsel = 3'h0;
	logic ea_n = 1'h1;
	logic tst = 1'h0;
	logic eb_n = 1'h1;
	logic cyc, stb, we, ack, den, irq_n, me, pulse_per_second_out, ase, gclk;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, rd;
	logic [3:0] sel, ant;
	logic [11:0] chan;
	rsc_port_t port;
	logic [31:0] rnd = 32'h5E;
	int bad_count = 0;
	int num_checks = 0;
	int wt, n0, ncyc = 0, drise = 0, mrise = 0, mlast = 0, mgap = 0;
	int prise = 0, plast = 0, pgap = 0;

	always #5 clk = ~clk;
	always #40 aux = ~aux;
	always @(posedge clk) ncyc++;
	always @(posedge gclk) drise++;
	always @(posedge me) begin
		mgap = ncyc - mlast;
		mlast = ncyc;
		mrise++;
	end
	always @(posedge pulse_per_second_out) begin
		pgap = ncyc - plast;
		plast = ncyc;
		prise++;
	end

	rsc_top #(.ME_CYC(ME), .PPS_CYC(PULSE_PER_SECOND_OUT)) i_dut (.i_ref_clk(clk),
		.i_sys_rst(sys_rst), .i_hw_rst_n(hw_n),
		.i_test_mode(tst),
		.i_aux_clock_in(aux), .i_aux_clock_divide_select(dsel),
		.i_external_interrupt_in_a_n(ea_n),
		.i_external_interrupt_in_b_n(eb_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
		.o_wb_dat(rdat), .o_wb_ack(ack), .o_host_bus_drive_en(den),
		.o_interrupt_request_out_n(irq_n), .o_measurement_epoch_out(me),
		.o_pulse_per_second_out(pulse_per_second_out), .o_antenna_switch_epoch_out(ase),
		.o_antenna_select_out(ant), .o_general_output_port(port),
		.o_divided_aux_clock_out(gclk), .o_channel_enable(chan));

	rsc_host_bfm i_host (.i_ref_clk(clk), .i_ack(ack), .i_dat(rdat),
		.o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_dat(wdat),
		.o_sel(sel));

	task automatic close_out();
		$display("Checks %0d, errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'h1) begin
			bad_count++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'h1, a, d, rd, wt);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		i_host.xfer(1'h0, a, 32'h0, rd, wt);
	endtask : rdr

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic int div_exp(input int n, input rsc_div_sel_t s);
		return (s == 3'h0) ? 0 : n / (int'(s) + 1);
	endfunction : div_exp

	// Counts divided clock rises over n aux periods
	task automatic div_chk(input int n);
		int e;
		e = div_exp(n, dsel);
		n0 = drise;
		repeat (n) @(posedge aux);
		chk(drise - n0 inside {[e - 1:e + 1]}, "divide ratio");
		@(posedge clk);
	endtask : div_chk

	// Pin reset with all interrupt input levels, then release
	task automatic hw_pulse(input rsc_div_sel_t s);
		hw_n <= 1'h0;
		dsel <= s;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			ea_n <= k[0];
			eb_n <= k[1];
			#1;
			chk({me, pulse_per_second_out, ase, ant, port, gclk, den} === '0, "held");
			chk(irq_n === (ea_n & eb_n), "irq in reset");
		end
		@(posedge clk);
		ea_n <= 1'h1;
		eb_n <= 1'h1;
		hw_n <= 1'h1;
		rdr(`RSC_ADR_STATUS);
		chk(wt >= 32 && rd[`RSC_ST_BUSY] === 1'h0
			&& rd[`RSC_ST_TEST] === 1'h0, "init time");
	endtask : hw_pulse

	initial begin
		#400000;
		bad_count++;
		close_out();
	end

	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		hw_pulse(3'h0);
		div_chk(64);
		rnd = xs(rnd);
		hw_pulse(3'h1 + 3'(rnd % 7));
		div_chk(16 * (int'(dsel) + 1));
		ea_n <= 1'h0;
		#1;
		chk(irq_n === 1'h1, "irq between edges");
		repeat (4) @(posedge clk);
		#1;
		chk(irq_n === 1'h0, "irq missed");
		@(posedge clk);
		ea_n <= 1'h1;
		rdr(`RSC_ADR_OUT_PORT);
		chk(rd[11:0] === `RSC_RST_OUT_PORT && port === 12'h000, "port init");
		chk(chan === 12'h000 && ant === `RSC_RST_ANT_SEL, "chan init");
		repeat (6) begin
			rnd = xs(rnd);
			wr(`RSC_ADR_OUT_PORT, rnd);
			rdr(`RSC_ADR_OUT_PORT);
			chk(rd[11:0] === rnd[11:0] && port === rnd[11:0]
				&& den === 1'h1, "port");
			wr(`RSC_ADR_CHAN_MODE, rnd >> 12);
			wr(`RSC_ADR_ANT_CTRL, {30'h0, rnd[13:12]});
			@(posedge clk);
			#1;
			chk(ant === 4'h1 << rnd[13:12] && chan === rnd[23:12]
				&& ase === 1'h1, "ant");
		end
		rdr(8'hFC);
		chk(rd === 32'h0 && wt === 2, "unmapped read");
		wr(`RSC_ADR_INT_CTRL, 32'h1);
		n0 = mrise;
		while (mrise == n0) @(posedge clk);
		@(posedge clk);
		#1;
		chk(irq_n === 1'h0, "epoch irq");
		rdr(`RSC_ADR_STATUS);
		chk(rd[`RSC_ST_ME_FLAG] === 1'h1, "epoch flag");
		wr(`RSC_ADR_STATUS, 32'h4);
		repeat (2) @(posedge clk);
		#1;
		chk(irq_n === 1'h1, "irq cleared");
		wr(`RSC_ADR_OUT_PORT, 32'hA5C);
		n0 = mrise;
		while (mrise == n0) @(posedge clk);
		n0 = mrise;
		rnd = xs(rnd);
		wr(`RSC_ADR_SOFT_RST, rnd);
		rdr(`RSC_ADR_OUT_PORT);
		chk(wt >= 30 && rd[11:0] === 12'h000, "soft init");
		chk({port, chan, ant, ase} === '0, "soft clear");
		while (mrise == n0) @(posedge clk);
		chk(mgap === ME, "epoch disturbed");
		div_chk(16 * (int'(dsel) + 1));
		n0 = prise;
		while (prise < n0 + 2) @(posedge clk);
		chk(pgap === PULSE_PER_SECOND_OUT, "pps period");
		tst <= 1'h1;
		n0 = mrise;
		while (mrise < n0 + 3) @(posedge clk);
		rdr(`RSC_ADR_STATUS);
		chk(mgap === `RSC_TEST_CYC && rd[`RSC_ST_TEST] === 1'h1, "test");
		close_out();
	end
endmodule : tb_reset_state_control

`default_nettype wire
